// ==== core/irq_regs_pkg.sv ====
package irq_regs_pkg;

  localparam int ADR_W  = 18;
  localparam int IDX_W  = 16;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_EN_TB_PWM  = 16'hf016;
  localparam logic [15:0] IDX_EN_TB_TWO  = 16'hf017;
  localparam logic [15:0] IDX_REQ_SYS    = 16'hf018;
  localparam logic [15:0] IDX_REQ_PINS   = 16'hf019;
  localparam logic [15:0] IDX_CTRL       = 16'hf030;
  localparam logic [15:0] IDX_EN_ZERO    = 16'hf031;
  localparam logic [15:0] IDX_EN_PINS    = 16'hf032;

  localparam logic [7:0] RST_REG8 = 8'h00;

  // implemented bit masks; everything else is reserved
  localparam logic [7:0] MASK_EN_TB_PWM = 8'haf;
  localparam logic [7:0] MASK_EN_TB_TWO = 8'h08;
  localparam logic [7:0] MASK_REQ_SYS   = 8'h45;
  localparam logic [7:0] MASK_REQ_PINS  = 8'hff;
  localparam logic [7:0] MASK_EN_ZERO   = 8'h40;
  localparam logic [7:0] MASK_EN_PINS   = 8'hff;

  localparam int BIT_WDT  = 0;
  localparam int BIT_CKC  = 2;
  localparam int BIT_LLD  = 6;
  localparam int BIT_MIE  = 0;
  localparam int BIT_HOLD = 1;

  // instructions to retire before a software raise is presented
  localparam int INSTR_DELAY = 1;

  typedef enum logic [3:0] {
    ACK_WDT, ACK_CKC, ACK_LLD,
    ACK_PIN0, ACK_PIN1, ACK_PIN2, ACK_PIN3,
    ACK_PIN4, ACK_PIN5, ACK_PIN6, ACK_PIN7
  } ack_src_t;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [3:0]       sel;
    logic [ADR_W-1:0] adr;
    logic [31:0]      dat;
  } wb_req_t;

  typedef struct packed {
    logic     valid;
    ack_src_t src;
  } cpu_ack_t;

  typedef struct packed {
    logic       wdt;
    logic       ckc;
    logic       lld;
    logic [7:0] pins;
  } src_events_t;

endpackage

// ==== core/flag_bank.sv ====
module flag_bank #(
  parameter int         W    = 8,
  parameter logic [7:0] IMPL = 8'hff
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // set and clear sources
  input  wire logic [W-1:0] hw_set_i,
  input  wire logic [W-1:0] hw_clr_i,
  input  wire logic         sw_wr_i,
  input  wire logic [W-1:0] sw_data_i,
  // flags
  output wire logic [W-1:0] flags_o
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      if (IMPL[i]) begin : g_impl
        logic flag_r;
        logic flag_nxt;
        // an event in the clearing cycle still sets the flag
        assign flag_nxt = hw_set_i[i] |
                          (sw_wr_i ? sw_data_i[i]
                                   : flag_r & ~hw_clr_i[i]);
        always_ff @(posedge clk_i) begin
          if (!rstn_i) flag_r <= 1'b0;
          else flag_r <= flag_nxt;
        end
        assign flags_o[i] = flag_r;
      end else begin : g_rsvd
        assign flags_o[i] = 1'b0;
      end
    end
  endgenerate

endmodule

// ==== core/instr_gate.sv ====
module instr_gate #(
  parameter int DELAY = irq_regs_pkg::INSTR_DELAY
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // events
  input  wire logic arm_i,
  input  wire logic instr_done_i,
  // gate
  output logic      hold_o
);

  localparam int CW = $clog2(DELAY + 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  // each new raise restarts the wait
  assign cnt_nxt = arm_i ? CW'(DELAY)
                 : (instr_done_i && cnt_r != '0) ? cnt_r - 1'b1
                 : cnt_r;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) cnt_r <= '0;
    else cnt_r <= cnt_nxt;
  end

  assign hold_o = (cnt_r != '0);

endmodule

// ==== core/interrupt_enable_request_regs.sv ====
module interrupt_enable_request_regs (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rstn_i,
  // wishbone classic slave
  input  wire irq_regs_pkg::wb_req_t    wb_req_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o,
  // peripheral event pulses
  input  wire irq_regs_pkg::src_events_t events_i,
  // cpu acceptance side
  input  wire irq_regs_pkg::cpu_ack_t   cpu_ack_i,
  input  wire logic                     instr_done_i,
  output logic                          nmi_req_o,
  output logic                          irq_req_o,
  output logic                          master_int_enable_o,
  // enable values towards the other sources
  output logic [7:0]                    enable_reg_timebase_pwm_o,
  output logic [7:0]                    enable_reg_timebase_two_o
);

  // ---------------- bus decode
  logic [15:0] idx;
  logic        acc;
  logic        wr_now;
  logic        hit_tb_pwm;
  logic        hit_tb_two;
  logic        hit_sys;
  logic        hit_pins;
  logic        hit_ctrl;
  logic        hit_en0;
  logic        hit_enp;
  logic        lane0;

  assign idx    = wb_req_i.adr[irq_regs_pkg::ADR_W-1:2];
  assign acc    = wb_req_i.cyc & wb_req_i.stb;
  assign lane0  = wb_req_i.sel[0];
  // write lands at the edge where ack is seen high
  assign wr_now = acc & wb_req_i.we & wb_ack_o & lane0;

  assign hit_tb_pwm = (idx == irq_regs_pkg::IDX_EN_TB_PWM);
  assign hit_tb_two = (idx == irq_regs_pkg::IDX_EN_TB_TWO);
  assign hit_sys    = (idx == irq_regs_pkg::IDX_REQ_SYS);
  assign hit_pins   = (idx == irq_regs_pkg::IDX_REQ_PINS);
  assign hit_ctrl   = (idx == irq_regs_pkg::IDX_CTRL);
  assign hit_en0    = (idx == irq_regs_pkg::IDX_EN_ZERO);
  assign hit_enp    = (idx == irq_regs_pkg::IDX_EN_PINS);

  logic [7:0] wdat;
  assign wdat = wb_req_i.dat[7:0];

  // ---------------- acknowledge decode
  function automatic logic [10:0] ack_mask(
    input irq_regs_pkg::cpu_ack_t a
  );
    logic [10:0] m;
    m = 11'h000;
    if (a.valid) m[a.src] = 1'b1;
    return m;
  endfunction

  logic [10:0] clr_all;
  logic [7:0]  clr_sys;
  logic [7:0]  clr_pins;

  assign clr_all  = ack_mask(cpu_ack_i);
  assign clr_sys  = {1'b0, clr_all[irq_regs_pkg::ACK_LLD], 3'b000,
                     clr_all[irq_regs_pkg::ACK_CKC], 1'b0,
                     clr_all[irq_regs_pkg::ACK_WDT]};
  assign clr_pins = clr_all[10:3];

  // ---------------- enable registers
  logic [7:0] en_tb_pwm_r;
  logic [7:0] en_tb_two_r;
  logic [7:0] en_zero_r;
  logic [7:0] en_pins_r;
  logic       mie_r;
  logic [7:0] en_tb_pwm_nxt;
  logic [7:0] en_tb_two_nxt;
  logic [7:0] en_zero_nxt;
  logic [7:0] en_pins_nxt;
  logic       mie_nxt;

  // only implemented bits store; cpu acceptance leaves them alone
  assign en_tb_pwm_nxt = (wr_now & hit_tb_pwm)
                       ? (wdat & irq_regs_pkg::MASK_EN_TB_PWM)
                       : en_tb_pwm_r;
  assign en_tb_two_nxt = (wr_now & hit_tb_two)
                       ? (wdat & irq_regs_pkg::MASK_EN_TB_TWO)
                       : en_tb_two_r;
  assign en_zero_nxt   = (wr_now & hit_en0)
                       ? (wdat & irq_regs_pkg::MASK_EN_ZERO)
                       : en_zero_r;
  assign en_pins_nxt   = (wr_now & hit_enp)
                       ? (wdat & irq_regs_pkg::MASK_EN_PINS)
                       : en_pins_r;
  // acceptance beats a simultaneous software enable
  assign mie_nxt = cpu_ack_i.valid ? 1'b0
                 : (wr_now & hit_ctrl) ? wdat[irq_regs_pkg::BIT_MIE]
                 : mie_r;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      en_tb_pwm_r <= irq_regs_pkg::RST_REG8;
      en_tb_two_r <= irq_regs_pkg::RST_REG8;
      en_zero_r   <= irq_regs_pkg::RST_REG8;
      en_pins_r   <= irq_regs_pkg::RST_REG8;
      mie_r       <= 1'b0;
    end else begin
      en_tb_pwm_r <= en_tb_pwm_nxt;
      en_tb_two_r <= en_tb_two_nxt;
      en_zero_r   <= en_zero_nxt;
      en_pins_r   <= en_pins_nxt;
      mie_r       <= mie_nxt;
    end
  end

  // ---------------- request flags
  logic [7:0] sys_set;
  logic [7:0] sys_flags;
  logic [7:0] pin_flags;

  assign sys_set = {1'b0, events_i.lld, 3'b000, events_i.ckc, 1'b0,
                    events_i.wdt};

  flag_bank #(
    .W    (8),
    .IMPL (irq_regs_pkg::MASK_REQ_SYS)
  ) u_sys_flags (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .hw_set_i  (sys_set),
    .hw_clr_i  (clr_sys),
    .sw_wr_i   (wr_now & hit_sys),
    .sw_data_i (wdat),
    .flags_o   (sys_flags)
  );

  flag_bank #(
    .W    (8),
    .IMPL (irq_regs_pkg::MASK_REQ_PINS)
  ) u_pin_flags (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .hw_set_i  (events_i.pins),
    .hw_clr_i  (clr_pins),
    .sw_wr_i   (wr_now & hit_pins),
    .sw_data_i (wdat),
    .flags_o   (pin_flags)
  );

  // ---------------- software raise delay
  logic sw_raise;
  logic hold;

  // a write to either request register or to the pin enable holds presentation back
  assign sw_raise = wr_now & (hit_sys | hit_pins | hit_enp);

  instr_gate #(
    .DELAY (irq_regs_pkg::INSTR_DELAY)
  ) u_gate (
    .clk_i        (clk_i),
    .rstn_i       (rstn_i),
    .arm_i        (sw_raise),
    .instr_done_i (instr_done_i),
    .hold_o       (hold)
  );

  // ---------------- presentation
  logic nmi_nxt;
  logic lld_live;
  logic pins_live;
  logic irq_nxt;
  logic nmi_r;
  logic irq_r;

  assign nmi_nxt   = ~hold & (sys_flags[irq_regs_pkg::BIT_WDT] |
                              sys_flags[irq_regs_pkg::BIT_CKC]);
  assign lld_live  = sys_flags[irq_regs_pkg::BIT_LLD] &
                     en_zero_r[irq_regs_pkg::BIT_LLD];
  assign pins_live = |(pin_flags & en_pins_r);
  assign irq_nxt   = ~hold & mie_r & (lld_live | pins_live);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      nmi_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      nmi_r <= nmi_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ---------------- read path and acknowledge
  logic [7:0]  ctrl_rd;
  logic [7:0]  rd_byte;
  logic [31:0] dat_r;
  logic        ack_r;
  logic [31:0] dat_nxt;
  logic        ack_nxt;

  assign ctrl_rd = {6'h00, hold, mie_r};
  // unmapped indices read as zero and still acknowledge
  assign rd_byte = hit_tb_pwm ? en_tb_pwm_r :
                   hit_tb_two ? en_tb_two_r :
                   hit_sys    ? sys_flags   :
                   hit_pins   ? pin_flags   :
                   hit_ctrl   ? ctrl_rd     :
                   hit_en0    ? en_zero_r   :
                   hit_enp    ? en_pins_r   : 8'h00;

  assign ack_nxt = acc & ~ack_r;
  assign dat_nxt = ack_nxt ? {24'h000000, rd_byte} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o                  = ack_r;
  assign wb_dat_o                  = dat_r;
  assign nmi_req_o                 = nmi_r;
  assign irq_req_o                 = irq_r;
  assign master_int_enable_o       = mie_r;
  assign enable_reg_timebase_pwm_o = en_tb_pwm_r;
  assign enable_reg_timebase_two_o = en_tb_two_r;

  // ---------------- checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_reset_zero;
    @(posedge clk_i) disable iff (1'b0)
      !rstn_i |=> (en_tb_pwm_r == 8'h00) && (en_tb_two_r == 8'h00) &&
                  (sys_flags == 8'h00) && (pin_flags == 8'h00);
  endproperty
  reset_regs_zero_a: assert property (p_reset_zero)
    else $error("register not zero after reset");

  accept_mie_clear_a: assert property (
    cpu_ack_i.valid |=> !mie_r && !master_int_enable_o)
    else $error("master enable survived acceptance");

  accept_en_keep_a: assert property (
    cpu_ack_i.valid && !wr_now |=> $stable(en_tb_pwm_r) &&
                                   $stable(en_tb_two_r))
    else $error("enable changed on acceptance");

  nmi_unmasked_a: assert property (
    !mie_r && !hold && sys_flags[irq_regs_pkg::BIT_WDT] |=> nmi_req_o)
    else $error("watchdog request not presented");

  irq_needs_mie_a: assert property (
    irq_req_o |-> $past(mie_r) && $past(lld_live | pins_live))
    else $error("maskable request without enables");

  event_sets_a: assert property (
    (events_i.wdt |=> sys_flags[0]) and (events_i.lld |=> sys_flags[6]))
    else $error("event did not set flag");

  sys_rsvd_zero_a: assert property (
    (sys_flags & 8'hba) == 8'h00 && (en_tb_pwm_r & 8'h50) == 8'h00 &&
    (en_tb_two_r & 8'hf7) == 8'h00)
    else $error("reserved bit set");

  accept_clear_a: assert property (
    cpu_ack_i.valid && cpu_ack_i.src == irq_regs_pkg::ACK_PIN3 &&
    !events_i.pins[3] && !(wr_now && hit_pins) |=> !pin_flags[3])
    else $error("accepted pin flag not cleared");

  // a request already pending before the write is not a software raise
  raise_delay_a: assert property (
    wr_now && hit_sys && !instr_done_i &&
    !sys_flags[irq_regs_pkg::BIT_WDT] && !sys_flags[irq_regs_pkg::BIT_CKC]
      |=> !nmi_req_o [*2])
    else $error("software raise presented early");

  pin_mask_a: assert property (
    events_i.pins == 8'h08 && !en_pins_r[3] && pin_flags == 8'h00 &&
    !wr_now && !events_i.lld && !lld_live |=> ##1 !irq_req_o)
    else $error("disabled pin presented");

  ack_single_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  sw_set_flag_a: assert property (
    wr_now && hit_sys && wdat[irq_regs_pkg::BIT_WDT] |=>
      sys_flags[irq_regs_pkg::BIT_WDT])
    else $error("software set of request lost");

  pin_event_sets_a: assert property (
    events_i.pins != 8'h00 |=>
      (pin_flags & $past(events_i.pins)) == $past(events_i.pins))
    else $error("pin event did not set its flag");

  hold_blocks_a: assert property (
    hold |=> !nmi_req_o && !irq_req_o)
    else $error("request presented while held");

  pin_enable_arm_a: assert property (
    wr_now && hit_enp |=> hold)
    else $error("pin enable write did not hold");

  tb_two_write_a: assert property (
    wr_now && hit_tb_two |=>
      enable_reg_timebase_two_o == ($past(wdat) & 8'h08))
    else $error("timebase two enable write wrong");

  tb_pwm_write_a: assert property (
    wr_now && hit_tb_pwm |=>
      enable_reg_timebase_pwm_o == ($past(wdat) & 8'haf))
    else $error("timebase pwm enable write wrong");

  ack_latency_a: assert property (
    acc && !wb_ack_o |=> wb_ack_o)
    else $error("access not acknowledged next cycle");

  dat_idle_zero_a: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside acknowledge");

  mie_write_a: assert property (
    wr_now && hit_ctrl && !cpu_ack_i.valid |=>
      master_int_enable_o == $past(wdat[irq_regs_pkg::BIT_MIE]))
    else $error("master enable write lost");

  lld_present_a: assert property (
    mie_r && !hold && lld_live |=> irq_req_o)
    else $error("enabled low level request not presented");

  pin_present_a: assert property (
    mie_r && !hold && pins_live |=> irq_req_o)
    else $error("enabled pin request not presented");

  backup_unmasked_a: assert property (
    !hold && sys_flags[irq_regs_pkg::BIT_CKC] |=> nmi_req_o)
    else $error("clock backup request not presented");

  watchdog_clear_a: assert property (
    cpu_ack_i.valid && cpu_ack_i.src == irq_regs_pkg::ACK_WDT &&
    !events_i.wdt && !(wr_now && hit_sys) |=> !sys_flags[0])
    else $error("accepted watchdog flag not cleared");

  cover_nmi_c:   cover property (events_i.ckc ##2 nmi_req_o);
  cover_irq_c:   cover property (mie_r && events_i.pins[0] ##2 irq_req_o);
  cover_accept_c: cover property (irq_req_o ##1 cpu_ack_i.valid);
  cover_swraise_c: cover property (wr_now && hit_sys ##[1:20] nmi_req_o);
  cover_pin_c:   cover property (events_i.pins[3] ##1 pin_flags[3]);

endmodule

// ==== tb/cpu_accept_model.sv ====
module cpu_accept_model (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  // requests from the block
  input  wire logic                   nmi_req_i,
  input  wire logic                   irq_req_i,
  // bench control
  input  wire logic                   run_i,
  input  wire logic                   accept_en_i,
  input  wire logic                   slow_i,
  input  wire irq_regs_pkg::ack_src_t src_i,
  // towards the block
  output irq_regs_pkg::cpu_ack_t      cpu_ack_o,
  output logic                        instr_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_r;
  logic       taken_r;
  wire        seen = nmi_req_i | irq_req_i;
  wire [1:0]  lat  = slow_i ? 2'h3 : 2'h0;
  // one acceptance per grant, so a stale request is never taken twice
  always_ff @(posedge clk_i) begin
    cpu_ack_o.valid <= 1'b0;
    cpu_ack_o.src   <= src_i;
    instr_done_o    <= rstn_i & run_i & ~instr_done_o;
    if (!rstn_i || !accept_en_i) begin
      wait_r  <= 2'h0;
      taken_r <= 1'b0;
    end else if (!taken_r && seen) begin
      if (wait_r == lat) begin
        cpu_ack_o.valid <= 1'b1;
        taken_r         <= 1'b1;
      end else begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule

// ==== tb/interrupt_enable_request_regs_test.sv ====
module interrupt_enable_request_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk_i;
  logic                     rstn_i;
  irq_regs_pkg::wb_req_t    wb_req;
  logic [31:0]              wb_dat;
  logic                     wb_ack;
  irq_regs_pkg::src_events_t events;
  irq_regs_pkg::cpu_ack_t   cpu_ack;
  irq_regs_pkg::ack_src_t   acc_src;
  logic                     instr_done;
  logic                     nmi;
  logic                     irq;
  logic                     master_int_enable;
  logic [7:0]               en_pwm;
  logic [7:0]               en_two;
  logic                     run;
  logic                     acc_en;
  logic                     acc_slow;
  logic [23:0]              exp_q[$];
  logic [23:0]              e;
  logic [7:0]               v;
  logic [15:0]              ix[4] = '{16'hf016, 16'hf017, 16'hf018, 16'hf019};
  logic [7:0]               mk[4] = '{8'haf, 8'h08, 8'h45, 8'hff};
  int                       failures = 0;
  int                       n_tests = 0;

  interrupt_enable_request_regs dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat),
    .wb_ack_o(wb_ack), .events_i(events), .cpu_ack_i(cpu_ack),
    .instr_done_i(instr_done), .nmi_req_o(nmi), .irq_req_o(irq),
    .master_int_enable_o(master_int_enable), .enable_reg_timebase_pwm_o(en_pwm),
    .enable_reg_timebase_two_o(en_two));

  cpu_accept_model cpu (
    .clk_i(clk_i), .rstn_i(rstn_i), .nmi_req_i(nmi), .irq_req_i(irq),
    .run_i(run), .accept_en_i(acc_en), .slow_i(acc_slow), .src_i(acc_src),
    .cpu_ack_o(cpu_ack), .instr_done_o(instr_done));

  initial clk_i = 1'b0;
  always #12.5 clk_i = ~clk_i;

  task check(input string w, input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", w, x, s);
    end
  endtask

  task finish_test;
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // holds the request until ack is sampled, then releases
  task bus(input logic we, input logic [15:0] a, input logic [7:0] d,
           input logic [3:0] sel);
    @(posedge clk_i);
    wb_req <= '{1'b1, 1'b1, we, sel, {a, 2'b00}, {24'h0, d}};
    // only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    check("ack", {31'h0, wb_ack}, 32'h1);
    wb_req <= '0;
  endtask

  task wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task rd(input logic [15:0] a, input logic [7:0] x);
    exp_q.push_back({a, x});
    bus(1'b0, a, 8'h00, 4'h1);
  endtask

  always @(posedge clk_i) begin
    if (wb_ack === 1'b1 && !wb_req.we) begin
      e = exp_q.pop_front();
      check($sformatf("reg %h", e[23:8]), wb_dat, {24'h0, e[7:0]});
    end
  end

  task ev(input logic [10:0] x);
    @(posedge clk_i);
    events <= irq_regs_pkg::src_events_t'(x);
    @(posedge clk_i);
    events <= '0;
  endtask

  function automatic logic pick(input int w);
    return (w == 0) ? nmi : irq;
  endfunction

  task wait_out(input int w, input logic x);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pick(w) !== x && n < 8);
    check(w == 0 ? "nmi" : "irq", {31'h0, pick(w)}, {31'h0, x});
  endtask

  task stay_low(input int w);
    repeat (6) begin
      @(posedge clk_i);
      check(w == 0 ? "nmi" : "irq", {31'h0, pick(w)}, 32'h0);
    end
  endtask

  task accept(input irq_regs_pkg::ack_src_t s, input logic slow);
    int n;
    n = 0;
    @(posedge clk_i);
    acc_src  <= s;
    acc_slow <= slow;
    acc_en   <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (cpu_ack.valid !== 1'b1 && n < 12);
    check("accept", {31'h0, cpu_ack.valid}, 32'h1);
    acc_en <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    finish_test();
  end

  initial begin
    rstn_i = 1'b0;
    wb_req = '0;
    events = '0;
    run = 1'b1;
    acc_en = 1'b0;
    acc_slow = 1'b0;
    acc_src = irq_regs_pkg::ACK_WDT;
    void'($urandom(32'h3f47));
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 4; i++) rd(ix[i], 8'h00);
    rd(16'h0123, 8'h00);
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 3; k++) begin
        v = (k == 0) ? 8'hff : 8'($urandom);
        wr(ix[i], v);
        rd(ix[i], v & mk[i]);
      end
    end
    wr(16'hf018, 8'h00);
    wr(16'hf019, 8'h00);
    wait_out(0, 1'b0);
    wr(16'hf016, 8'hf5);
    bus(1'b1, 16'hf016, 8'h00, 4'h0);
    wr(16'hf017, 8'hff);
    @(posedge clk_i);
    check("en_pwm", {24'h0, en_pwm}, 32'ha5);
    check("en_two", {24'h0, en_two}, 32'h08);
    // non-maskable sources with the master enable still clear
    for (int j = 0; j < 2; j++) begin
      ev(j == 0 ? 11'h400 : 11'h200);
      wait_out(0, 1'b1);
      rd(16'hf018, j == 0 ? 8'h01 : 8'h04);
      accept(j == 0 ? irq_regs_pkg::ACK_WDT : irq_regs_pkg::ACK_CKC, j[0]);
      wait_out(0, 1'b0);
      rd(16'hf018, 8'h00);
    end
    ev(11'h100);
    rd(16'hf018, 8'h40);
    stay_low(1);
    wr(16'hf031, 8'h40);
    stay_low(1);
    wr(16'hf030, 8'h01);
    wait_out(1, 1'b1);
    accept(irq_regs_pkg::ACK_LLD, 1'b1);
    wait_out(1, 1'b0);
    check("mie", {31'h0, master_int_enable}, 32'h0);
    check("en_pwm", {24'h0, en_pwm}, 32'ha5);
    rd(16'hf031, 8'h40);
    ev(11'h008);
    rd(16'hf019, 8'h08);
    stay_low(1);
    wr(16'hf032, 8'h08);
    wr(16'hf030, 8'h01);
    wait_out(1, 1'b1);
    accept(irq_regs_pkg::ACK_PIN3, 1'b0);
    wait_out(1, 1'b0);
    rd(16'hf019, 8'h00);
    // no instruction retires, so a software raise must stay hidden
    run <= 1'b0;
    wr(16'hf018, 8'h01);
    stay_low(0);
    run <= 1'b1;
    wait_out(0, 1'b1);
    accept(irq_regs_pkg::ACK_WDT, 1'b0);
    wait_out(0, 1'b0);
    wr(16'hf030, 8'h01);
    run <= 1'b0;
    wr(16'hf019, 8'h01);
    wr(16'hf032, 8'h09);
    stay_low(1);
    run <= 1'b1;
    wait_out(1, 1'b1);
    accept(irq_regs_pkg::ACK_PIN0, 1'b0);
    wait_out(1, 1'b0);
    rd(16'hf019, 8'h00);
    rd(16'hf032, 8'h09);
    rd(16'hf030, 8'h00);
    repeat (4) @(posedge clk_i);
    finish_test();
  end
endmodule
